/* design/rasc_pkg.sv */
package rasc_pkg;
  localparam int NRANGE = 8;
  localparam int NQ     = 5;
  localparam int NCH    = 2;

  // Register byte offsets
  localparam logic [5:0] OFS_AUTO = 6'h00;
  localparam logic [5:0] OFS_VRNG = 6'h04;
  localparam logic [5:0] OFS_IRNG = 6'h08;
  localparam logic [5:0] OFS_RSEL = 6'h0C;
  localparam logic [5:0] OFS_ZCF  = 6'h10;
  localparam logic [5:0] OFS_MN   = 6'h14;
  localparam logic [5:0] OFS_VTR  = 6'h18;
  localparam logic [5:0] OFS_CTR  = 6'h1C;
  localparam logic [5:0] OFS_STAT = 6'h20;

  // Field positions
  localparam int RSEL_I_LSB = 8;
  localparam int ZCF_I_LSB  = 8;

  // Reset values and ratio limits
  localparam logic [2:0]  RANGE_RST = 3'h7;
  localparam logic [7:0]  MASK_RST  = 8'hFF;
  localparam logic [3:0]  ZCF_RST   = 4'h1;
  localparam logic [7:0]  MEANN_RST = 8'h01;
  localparam logic [19:0] RATIO_ONE = 20'h003E8;
  localparam logic [19:0] RATIO_MIN = 20'h00001;
  localparam logic [19:0] RATIO_MAX = 20'hF4240;

  // Ranging thresholds in percent of range
  localparam logic [15:0] UP_PCT   = 16'h0096;
  localparam logic [15:0] DN_PCT   = 16'h000F;
  localparam logic [15:0] PEAK_PCT = 16'h0258;

  // Full scale per range, volts for channel 0, amps for channel 1
  localparam logic [NCH-1:0][NRANGE-1:0][9:0] FS = {
    {10'h0C8, 10'h064, 10'h032, 10'h014, 10'h00A, 10'h005, 10'h002, 10'h001},
    {10'h3E8, 10'h258, 10'h12C, 10'h096, 10'h03C, 10'h01E, 10'h00F, 10'h006}};

  // 99,999 M in watts times the square of the ratio scale of 1000
  localparam logic [63:0] PWR_LIMIT = 64'h1869F * 64'hE8D4A51000;

  localparam int DIV_STEPS = 40;
  localparam int CLK_MHZ   = 100;
  localparam int BLINK_MS  = 250;
  localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;

  typedef struct packed {
    logic                 stb;
    logic [NQ-1:0]        over;
    logic [NQ-1:0][31:0]  val;
  } rasc_meas_s;

  typedef struct packed {
    logic                 stb;
    logic [NCH-1:0][15:0] rms_pct;
    logic [NCH-1:0][15:0] peak_pct;
    logic [NCH-1:0]       peak_over;
  } rasc_lvl_s;
endpackage

/* design/rasc_mean.sv */
`timescale 1ns/1ps
module rasc_mean (
  input  logic               clk,
  input  logic               rst_n,
  input  logic               restart,
  input  logic [7:0]         n,
  input  logic               in_stb,
  input  logic signed [31:0] in_val,
  input  logic               in_over,
  output logic               out_stb,
  output logic signed [31:0] out_val,
  output logic               out_over,
  output logic               have
);
  logic signed [39:0] acc_q;
  logic [7:0]         cnt_q;
  logic               or_q;
  logic               bor_q;
  logic               neg_q;
  logic               busy_q;
  logic [39:0]        dq_q;
  logic [7:0]         rem_q;
  logic [5:0]         k_q;
  logic signed [39:0] sum;
  logic               last;
  logic [8:0]         trial;
  logic               fits;
  logic [39:0]        quo;

  assign sum   = acc_q + 40'(in_val);
  assign last  = in_stb && (cnt_q + 8'h01 >= n);
  assign trial = {rem_q, dq_q[39]};
  assign fits  = trial >= {1'b0, n};
  assign quo   = {dq_q[38:0], fits};

  // Serial divide keeps area small; samples must be spaced over 40 cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0; cnt_q <= '0; or_q <= 1'b0; bor_q <= 1'b0; neg_q <= 1'b0;
      busy_q <= 1'b0; dq_q <= '0; rem_q <= '0; k_q <= '0;
      out_stb <= 1'b0; out_val <= '0; out_over <= 1'b0; have <= 1'b0;
    end else if (restart) begin
      acc_q <= '0; cnt_q <= '0; or_q <= 1'b0; busy_q <= 1'b0;
      out_stb <= 1'b0; have <= 1'b0;
    end else begin
      out_stb <= 1'b0;
      if (in_stb) begin
        acc_q <= last ? '0 : sum;
        cnt_q <= last ? '0 : cnt_q + 8'h01;
        or_q  <= last ? 1'b0 : (or_q | in_over);
      end
      if (busy_q) begin
        dq_q  <= quo;
        rem_q <= fits ? 8'(trial - {1'b0, n}) : trial[7:0];
        k_q   <= k_q + 6'h01;
        if (k_q == 6'(rasc_pkg::DIV_STEPS - 1)) begin
          busy_q   <= 1'b0;
          out_stb  <= 1'b1;
          have     <= 1'b1;
          out_val  <= neg_q ? -$signed(quo[31:0]) : $signed(quo[31:0]);
          out_over <= bor_q;
        end
      end else if (last) begin
        busy_q <= 1'b1;
        k_q    <= '0;
        rem_q  <= '0;
        neg_q  <= sum[39];
        bor_q  <= or_q | in_over;
        dq_q   <= sum[39] ? 40'(-sum) : 40'(sum);
      end
    end
  end
endmodule // rasc_mean

/* design/rasc_top.sv */
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// Summary of operation
// - Auto key toggles; range key forces off
// - Step up above 150% or peak over
// - Step down below 15% of range
// - No step down if lower peak overflows
// - Multi-range jumps, disabled ranges skipped
// - Auto ranging off after reset
// - Enabled range selectable manually and automatically
// - Disabled range refused and never auto-chosen
// - Zero-cross threshold per channel, 1 to 15
// - Range-select lamp on disabled range or threshold
// - Reset: all ranges enabled, threshold 1%
// - Mean only V, I, P, S, Q
// - Power factor uses averaged quantities
// - Mean lamp lit when count not 1
// - Lamp flashes, data invalid until first mean
// - Over-range sample flashes that unit
// - Mean restarts on reset, zero, settings
// - Mean count 1 after reset
// - Ratios 0.001 to 1000, 1.0 means off
// - Ratio lamps lit when ratio not 1
// - Scaling error above 99,999 M full scale
// - Ratios 1.0 after reset
module rasc_top #(
  parameter int BLINK_CYC = rasc_pkg::BLINK_CYC
) (
  input  logic                           clk,
  input  logic                           arst_n,
  input  logic [5:0]                     address,
  input  logic                           read,
  input  logic                           write,
  input  logic [31:0]                    writedata,
  output logic [31:0]                    readdata,
  output logic                           waitrequest,
  input  rasc_pkg::rasc_lvl_s            lvl,
  input  rasc_pkg::rasc_meas_s           meas_in,
  input  logic [31:0]                    other_in,
  input  logic                           zero_adj_done,
  output rasc_pkg::rasc_meas_s           meas_out,
  output logic [31:0]                    other_out,
  output logic                           data_invalid,
  output logic [1:0][2:0]                range_out,
  output logic [1:0][3:0]                zcf_out,
  output logic [19:0]                    voltage_transformer_ratio,
  output logic [19:0]                    current_transformer_ratio,
  output logic                           auto_ind,
  output logic                           range_sel_ind,
  output logic                           averaging_indicator,
  output logic                           voltage_transformer_ratio_ind,
  output logic                           current_transformer_ratio_ind,
  output logic                           scaling_err,
  output logic [4:0]                     unit_flash
);
  localparam int NQ = rasc_pkg::NQ;

  logic [1:0]        rst_sync_q;
  logic              rst_n;
  logic              ack_q;
  logic              wr_go;
  logic              wr_auto;
  logic [1:0]        wr_rng;
  logic              wr_rsel;
  logic              wr_zcf;
  logic              wr_n;
  logic              wr_vtr;
  logic              wr_ctr;
  logic              auto_q;
  logic [1:0][2:0]   range_q;
  logic [1:0][2:0]   range_d;
  logic [1:0][7:0]   mask_q;
  logic [1:0][3:0]   zcf_q;
  logic [7:0]        mean_n_q;
  logic [19:0]       vtr_q;
  logic [19:0]       ctr_q;
  logic [1:0]        key_ok;
  logic              range_chg;
  logic              n_chg;
  logic              vtr_ok;
  logic              ctr_ok;
  logic              restart;
  logic [NQ-1:0]     q_stb;
  logic [NQ-1:0]     q_over;
  logic [NQ-1:0]     q_have;
  logic [NQ-1:0][31:0] q_val;
  logic [24:0]       blink_cnt_q;
  logic              blink_q;
  logic              mean_on;
  logic [19:0]       pwr_fs;
  logic [63:0]       pwr_scaled;
  logic              err_q;
  logic [31:0]       other_q;
  logic [31:0]       status;
  logic [31:0]       rd_mux;
  logic [31:0]       rd_q;

  function automatic logic [2:0] lo_idx(input logic [7:0] m);
    lo_idx = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (m[k]) lo_idx = 3'(k);
    end
  endfunction

  function automatic logic [2:0] hi_idx(input logic [7:0] m);
    hi_idx = 3'h0;
    for (int k = 0; k < 8; k++) begin
      if (m[k]) hi_idx = 3'(k);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rst_sync_q <= 2'h0;
    else         rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, answer on the second
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_go       = write & ack_q;
  assign wr_auto     = wr_go && address == rasc_pkg::OFS_AUTO;
  assign wr_rng[0]   = wr_go && address == rasc_pkg::OFS_VRNG;
  assign wr_rng[1]   = wr_go && address == rasc_pkg::OFS_IRNG;
  assign wr_rsel     = wr_go && address == rasc_pkg::OFS_RSEL;
  assign wr_zcf      = wr_go && address == rasc_pkg::OFS_ZCF;
  assign wr_n        = wr_go && address == rasc_pkg::OFS_MN;
  assign wr_vtr      = wr_go && address == rasc_pkg::OFS_VTR;
  assign wr_ctr      = wr_go && address == rasc_pkg::OFS_CTR;

  assign status = {20'h00000, q_over, err_q, current_transformer_ratio_ind,
                   voltage_transformer_ratio_ind, data_invalid, mean_on, range_sel_ind, auto_q};
  // Unmapped offsets read as zero
  assign rd_mux = address == rasc_pkg::OFS_AUTO ? {31'h0, auto_q} :
                  address == rasc_pkg::OFS_VRNG ? {29'h0, range_q[0]} :
                  address == rasc_pkg::OFS_IRNG ? {29'h0, range_q[1]} :
                  address == rasc_pkg::OFS_RSEL ? {16'h0, mask_q[1], mask_q[0]} :
                  address == rasc_pkg::OFS_ZCF  ? {20'h0, zcf_q[1], 4'h0, zcf_q[0]} :
                  address == rasc_pkg::OFS_MN   ? {24'h0, mean_n_q} :
                  address == rasc_pkg::OFS_VTR  ? {12'h0, vtr_q} :
                  address == rasc_pkg::OFS_CTR  ? {12'h0, ctr_q} :
                  address == rasc_pkg::OFS_STAT ? status : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rd_q  <= 32'h0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
      if (read & ~ack_q) rd_q <= rd_mux;
    end
  end
  assign readdata = rd_q;

  //////////////////////////////////////////////////////////////////////////
  // Range control per channel, 0 voltage, 1 current
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [31:0] lvl_fs;
    logic [31:0] pk_fs;
    logic [7:0]  fit;
    logic [7:0]  above;
    logic [7:0]  below;
    logic [7:0]  up_set;
    logic [7:0]  dn_set;
    logic        need_up;
    logic        need_dn;
    logic        up_any;
    logic [2:0]  tgt;
    logic        step;

    assign lvl_fs = 32'(lvl.rms_pct[c]) * 32'(rasc_pkg::FS[c][range_q[c]]);
    assign pk_fs  = 32'(lvl.peak_pct[c]) * 32'(rasc_pkg::FS[c][range_q[c]]);
    // Candidate must be enabled, under 150% and inside its own peak limit
    for (genvar j = 0; j < 8; j++) begin : g_r
      assign fit[j] = mask_q[c][j] &&
                      lvl_fs < 32'(rasc_pkg::UP_PCT) * 32'(rasc_pkg::FS[c][j]) &&
                      pk_fs <= 32'(rasc_pkg::PEAK_PCT) * 32'(rasc_pkg::FS[c][j]);
    end
    assign above   = 8'hFE << range_q[c];
    assign below   = ~(8'hFF << range_q[c]);
    assign need_up = lvl.peak_over[c] || lvl.rms_pct[c] > rasc_pkg::UP_PCT;
    assign need_dn = lvl.rms_pct[c] < rasc_pkg::DN_PCT;
    assign up_set  = fit & above;
    assign dn_set  = fit & below;
    assign up_any  = |(mask_q[c] & above);
    // Lowest fitting range wins, possibly several steps away
    assign tgt  = need_up ? (|up_set ? lo_idx(up_set) : hi_idx(mask_q[c] & above))
                          : lo_idx(dn_set);
    assign step = auto_q && lvl.stb && (need_up ? up_any : (need_dn && |dn_set));
    assign key_ok[c]  = wr_rng[c] && mask_q[c][writedata[2:0]];
    assign range_d[c] = key_ok[c] ? writedata[2:0] : (step ? tgt : range_q[c]);
  end

  assign range_chg = range_d != range_q;
  assign n_chg     = wr_n && writedata[7:0] != 8'h00 && writedata[7:0] != mean_n_q;
  assign vtr_ok    = writedata[19:0] >= rasc_pkg::RATIO_MIN && writedata[19:0] <= rasc_pkg::RATIO_MAX;
  assign ctr_ok    = vtr_ok;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_q   <= 1'b0;
      range_q  <= {2{rasc_pkg::RANGE_RST}};
      mask_q   <= {2{rasc_pkg::MASK_RST}};
      zcf_q    <= {2{rasc_pkg::ZCF_RST}};
      mean_n_q <= rasc_pkg::MEANN_RST;
      vtr_q    <= rasc_pkg::RATIO_ONE;
      ctr_q    <= rasc_pkg::RATIO_ONE;
    end else begin
      auto_q  <= |wr_rng ? 1'b0 : (wr_auto ? ~auto_q : auto_q);
      range_q <= range_d;
      if (wr_rsel) mask_q <= {writedata[rasc_pkg::RSEL_I_LSB +: 8], writedata[7:0]};
      // Zero threshold codes are ignored, so each stays within 1 to 15
      if (wr_zcf && writedata[3:0] != 4'h0) zcf_q[0] <= writedata[3:0];
      if (wr_zcf && writedata[rasc_pkg::ZCF_I_LSB +: 4] != 4'h0) begin
        zcf_q[1] <= writedata[rasc_pkg::ZCF_I_LSB +: 4];
      end
      if (n_chg) mean_n_q <= writedata[7:0];
      if (wr_vtr && vtr_ok) vtr_q <= writedata[19:0];
      if (wr_ctr && ctr_ok) ctr_q <= writedata[19:0];
    end
  end

  assign auto_ind      = auto_q;
  assign range_out     = range_q;
  assign zcf_out       = zcf_q;
  assign range_sel_ind = mask_q[0] != rasc_pkg::MASK_RST || mask_q[1] != rasc_pkg::MASK_RST ||
                         zcf_q[0] != rasc_pkg::ZCF_RST || zcf_q[1] != rasc_pkg::ZCF_RST;

  //////////////////////////////////////////////////////////////////////////
  // Averaging of the five basic quantities
  assign restart = zero_adj_done || range_chg || n_chg ||
                   (wr_vtr && vtr_ok && writedata[19:0] != vtr_q) ||
                   (wr_ctr && ctr_ok && writedata[19:0] != ctr_q);

  for (genvar q = 0; q < NQ; q++) begin : g_q
    rasc_mean u_mean (
      .clk      (clk),
      .rst_n    (rst_n),
      .restart  (restart),
      .n        (mean_n_q),
      .in_stb   (meas_in.stb),
      .in_val   (meas_in.val[q]),
      .in_over  (meas_in.over[q]),
      .out_stb  (q_stb[q]),
      .out_val  (q_val[q]),
      .out_over (q_over[q]),
      .have     (q_have[q])
    );
  end

  // Power factor and phase downstream take these averaged words
  assign meas_out = {q_stb[0], q_over, q_val};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) other_q <= 32'h0;
    else        other_q <= other_in;
  end
  assign other_out = other_q;

  //////////////////////////////////////////////////////////////////////////
  // Lamps and flashing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_q <= 25'h0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == 25'(BLINK_CYC - 1)) begin
      blink_cnt_q <= 25'h0;
      blink_q     <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 25'h1;
    end
  end

  assign mean_on             = mean_n_q != rasc_pkg::MEANN_RST;
  assign data_invalid        = mean_on && !(&q_have);
  assign averaging_indicator = mean_on && (data_invalid ? blink_q : 1'b1);
  assign unit_flash          = q_over & {NQ{blink_q}};

  assign voltage_transformer_ratio     = vtr_q;
  assign current_transformer_ratio     = ctr_q;
  assign voltage_transformer_ratio_ind = vtr_q != rasc_pkg::RATIO_ONE;
  assign current_transformer_ratio_ind = ctr_q != rasc_pkg::RATIO_ONE;

  // Wide product kept combinational; err registered to cut the path
  assign pwr_fs     = 20'(rasc_pkg::FS[0][range_q[0]]) * 20'(rasc_pkg::FS[1][range_q[1]]);
  assign pwr_scaled = 64'(pwr_fs) * 64'(vtr_q) * 64'(ctr_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) err_q <= 1'b0;
    else        err_q <= pwr_scaled > rasc_pkg::PWR_LIMIT;
  end
  assign scaling_err = err_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_state : assert property ($rose(rst_n) |-> !auto_q && mean_n_q == 8'h01)
    else $error("auto or mean count wrong after reset");
  a_reset_sel : assert property ($rose(rst_n) |-> !range_sel_ind && !scaling_err)
    else $error("range select lamp lit after reset");
  a_reset_ratio : assert property ($rose(rst_n) |-> vtr_q == 20'h003E8 && ctr_q == 20'h003E8)
    else $error("ratios not one after reset");
  a_auto_toggle : assert property (wr_auto |=> auto_q != $past(auto_q))
    else $error("auto key did not toggle");
  a_key_off : assert property (|wr_rng |=> !auto_q)
    else $error("range key left auto on");
  a_key_refuse : assert property (wr_rng[0] && !mask_q[0][writedata[2:0]] && !auto_q
                                  |=> range_q[0] == $past(range_q[0]))
    else $error("disabled range accepted");
  // Manual key to an enabled range wins over a level update in the same cycle
  a_step_up : assert property (g_ch[0].step && g_ch[0].need_up && !wr_rng[0]
                               |=> range_q[0] > $past(range_q[0]))
    else $error("range did not go up");
  a_step_dn : assert property (g_ch[0].step && !g_ch[0].need_up && !wr_rng[0]
                               |=> range_q[0] < $past(range_q[0]))
    else $error("range did not go down");
  a_peak_hold : assert property (auto_q && lvl.stb && lvl.rms_pct[0] < 16'h000F && !lvl.peak_over[0]
                                 && !(|g_ch[0].dn_set) && !wr_rng[0] |=> $stable(range_q[0]))
    else $error("stepped down into peak overload");
  a_auto_enabled : assert property (g_ch[0].step && !wr_rsel |=> mask_q[0][range_q[0]])
    else $error("auto chose disabled range");
  a_invalid_start : assert property (restart && mean_on && !n_chg |=> data_invalid [*2])
    else $error("data valid right after restart");
  a_mean_lamp : assert property (!data_invalid |-> averaging_indicator == (mean_n_q != 8'h01))
    else $error("averaging lamp wrong");
  a_mean_flash : assert property (data_invalid |-> averaging_indicator == blink_q)
    else $error("averaging lamp not flashing");
  a_other_pass : assert property (other_out == $past(other_in))
    else $error("unaveraged word altered");
  a_ratio_lamp : assert property (wr_vtr && vtr_ok && writedata[19:0] != 20'h003E8
                                  |=> voltage_transformer_ratio_ind)
    else $error("ratio lamp dark");
  a_scale_err : assert property (##1 scaling_err == ($past(pwr_scaled) > rasc_pkg::PWR_LIMIT))
    else $error("scaling error mismatch");

  c_auto_up   : cover property (g_ch[0].step && g_ch[0].need_up);
  c_auto_down : cover property (g_ch[0].step && !g_ch[0].need_up);
  c_mean_out  : cover property (mean_on && q_stb[0]);
  c_zero_rst  : cover property (zero_adj_done && mean_on);
  c_scale_err : cover property ($rose(scaling_err));
endmodule // rasc_top

/* testbench/rasc_panel_model.sv */
`timescale 1ns/1ps
module rasc_panel_model (
  input  logic                 clk,
  output rasc_pkg::rasc_lvl_s  lvl,
  output rasc_pkg::rasc_meas_s meas
);
  initial begin
    lvl  = '0;
    meas = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level update, voltage channel driven, current held mid-range
  task automatic level(input logic [15:0] rms, input logic [15:0] pk, input logic po);
    @(posedge clk);
    lvl.stb         <= 1'b1;
    lvl.rms_pct     <= {16'h0032, rms};
    lvl.peak_pct    <= {16'h0064, pk};
    lvl.peak_over   <= {1'b0, po};
    @(posedge clk);
    lvl.stb         <= 1'b0;
    // Stale level is scrambled, never left looking valid
    lvl.rms_pct     <= ~lvl.rms_pct;
    lvl.peak_pct    <= ~lvl.peak_pct;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One sample per call, quantity q carries v plus q; idle gap first keeps samples 46 cycles apart
  task automatic sample(input logic [31:0] v, input logic [4:0] ov);
    repeat (44) @(posedge clk);
    @(posedge clk);
    meas.stb  <= 1'b1;
    meas.over <= ov;
    for (int q = 0; q < 5; q++) begin
      meas.val[q] <= v + q;
    end
    @(posedge clk);
    meas.stb  <= 1'b0;
    meas.val  <= ~meas.val;
  endtask
endmodule // rasc_panel_model

/* testbench/range_average_scaling_control_tb_top.sv */
`timescale 1ns/1ps
module range_average_scaling_control_tb_top;
  logic                 clk, arst_n, read, write, waitrequest, zero_adj_done, data_invalid;
  logic                 auto_ind, range_sel_ind, mean_ind, vratio_ind, cratio_ind, scaling_err;
  logic [5:0]           address;
  logic [31:0]          writedata, readdata, other_in, other_out, rv;
  logic [1:0][2:0]      range_out;
  logic [1:0][3:0]      zcf_out;
  logic [19:0]          vtr, ctr;
  logic [4:0]           unit_flash, fl_or, fl_and;
  rasc_pkg::rasc_lvl_s  lvl;
  rasc_pkg::rasc_meas_s meas_in, meas_out;
  int                   failures, checked;
  logic [5:0]           ra [9] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h24};
  logic [31:0]          re [9] = '{32'h0, 32'h7, 32'h7, 32'hFFFF, 32'h101, 32'h1, 32'h3E8, 32'h3E8, 32'h0};
  logic [15:0]          lr [4] = '{16'h00C8, 16'h000A, 16'h000A, 16'h0032};
  logic [15:0]          lp [4] = '{16'h00C8, 16'h0014, 16'h01F4, 16'h02BC};
  logic [2:0]           le [4] = '{3'h4, 3'h1, 3'h1, 3'h2};

  rasc_top #(.BLINK_CYC(8)) dut (.clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .lvl(lvl), .meas_in(meas_in),
    .other_in(other_in), .zero_adj_done(zero_adj_done), .meas_out(meas_out), .other_out(other_out),
    .data_invalid(data_invalid), .range_out(range_out), .zcf_out(zcf_out), .voltage_transformer_ratio(vtr),
    .current_transformer_ratio(ctr), .auto_ind(auto_ind), .range_sel_ind(range_sel_ind),
    .averaging_indicator(mean_ind), .voltage_transformer_ratio_ind(vratio_ind),
    .current_transformer_ratio_ind(cratio_ind), .scaling_err(scaling_err), .unit_flash(unit_flash));
  rasc_panel_model pm (.clk(clk), .lvl(lvl), .meas(meas_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until the edge that samples waitrequest low; read data taken at that edge
  task automatic acc(input logic rd, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    read      <= rd;
    write     <= !rd;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rv = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(negedge clk);
  endtask

  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    failures++;
    conclude();
  end

  initial begin
    arst_n = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0;
    other_in = '0; zero_adj_done = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, ra[i], '0);
      chk("reset read", re[i], rv);
    end
    acc(1'b1, 6'h20, '0);
    chk("status idle", 32'h0, rv);
    acc(1'b0, 6'h10, 32'h0F05);
    chk("zcf", 32'hF5, zcf_out);
    acc(1'b0, 6'h10, 32'h0);
    acc(1'b1, 6'h10, '0);
    chk("zcf zero refused", 32'h0F05, rv);
    acc(1'b0, 6'h10, 32'h0101);
    acc(1'b0, 6'h0C, 32'hFFF7);
    chk("range sel lamp", 1, range_sel_ind);
    acc(1'b0, 6'h04, 32'h3);
    chk("disabled range", 7, range_out[0]);
    acc(1'b0, 6'h04, 32'h2);
    chk("enabled range", 2, range_out[0]);
    acc(1'b0, 6'h00, 32'h0);
    chk("auto on", 1, auto_ind);
    // Up over a disabled range, multi-range down, blocked down, peak-driven up
    for (int i = 0; i < 4; i++) begin
      pm.level(lr[i], lp[i], i == 3);
      repeat (3) @(negedge clk);
      chk("auto range", le[i], range_out[0]);
    end
    acc(1'b0, 6'h00, 32'h0);
    chk("auto off", 0, auto_ind);
    acc(1'b0, 6'h00, 32'h0);
    acc(1'b0, 6'h04, 32'h7);
    chk("key ends auto", 0, auto_ind);
    chk("key range", 7, range_out[0]);
    acc(1'b0, 6'h14, 32'h2);
    acc(1'b1, 6'h20, '0);
    chk("status averaging", 32'h0E, rv);
    pm.sample(32'd10, 5'h00);
    chk("invalid mid block", 1, data_invalid);
    pm.sample(32'd21, 5'h02);
    for (int i = 0; i < 100 && meas_out.stb !== 1'b1; i++) @(negedge clk);
    chk("mean strobe", 1, meas_out.stb);
    for (int q = 0; q < 5; q++) chk("mean", 15 + q, meas_out.val[q]);
    chk("over flag", 5'h02, meas_out.over);
    @(negedge clk);
    chk("valid after mean", 0, data_invalid);
    fl_or  = 5'h00;
    fl_and = 5'h1F;
    repeat (16) begin
      @(negedge clk);
      fl_or  = fl_or | unit_flash;
      fl_and = fl_and & unit_flash;
      chk("averaging lamp", 1, mean_ind);
    end
    chk("unit flash on", 5'h02, fl_or);
    chk("unit flash off", 5'h00, fl_and);
    @(posedge clk);
    other_in <= 32'h5A5A_A5A5;
    repeat (2) @(negedge clk);
    chk("other passes", 32'h5A5A_A5A5, other_out);
    @(posedge clk);
    zero_adj_done <= 1'b1;
    @(posedge clk);
    zero_adj_done <= 1'b0;
    @(negedge clk);
    chk("restart on zero", 1, data_invalid);
    acc(1'b0, 6'h18, 32'h0);
    acc(1'b0, 6'h18, 32'hF4241);
    chk("ratio refused", 20'h3E8, vtr);
    acc(1'b0, 6'h18, 32'hF4240);
    chk("ratio lamps", 2'b10, {vratio_ind, cratio_ind});
    chk("no scale err", 0, scaling_err);
    acc(1'b0, 6'h1C, 32'hF4240);
    @(negedge clk);
    chk("scale err", 1, scaling_err);
    conclude();
  end
endmodule // range_average_scaling_control_tb_top
